// File: design/rrr_regs.sv
`default_nettype none
module rrr_regs
  import rrr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ranging_mode_enable,
  input wire logic sync_peak,
  input wire logic [7:0] corr_mag_before_peak,
  input wire logic [7:0] corr_mag_at_peak,
  input wire logic [7:0] corr_mag_after_250,
  input wire logic [7:0] corr_mag_after_500,
  input wire logic [7:0] corr_mag_after_750,
  input wire logic [7:0] corr_mag_after_1000,
  input wire logic flight_start,
  input wire logic flight_stop,
  input wire logic header_detected,
  input wire logic freq_sample_valid,
  input wire logic [7:0] freq_sample,
  input wire logic frame_end,
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] freq_offset_value,
  output logic [23:0] flight_count
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] avg_byte(input logic [15:0] sum, input logic [7:0] n);
    logic signed [15:0] q;
    q = (n == 8'h00) ? 16'sh0000 : $signed(sum) / $signed({8'h00, n});
    if (q > 16'sd127)
      return 8'h7f;
    else if (q < -16'sd128)
      return 8'h80;
    else
      return q[7:0];
  endfunction

  function automatic logic is_tap_addr(input logic [6:0] a);
    return (a >= RRR_ADDR_TAP_BEFORE) && (a <= RRR_ADDR_TAP_1000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Correlator taps
  logic [7:0] tap_wr [RRR_TAP_COUNT];
  logic [7:0] tap_rd;
  logic [2:0] tap_index;
  logic tap_wr_en;

  always_comb
  begin
    tap_wr[0] = corr_mag_before_peak;
    tap_wr[1] = corr_mag_at_peak;
    tap_wr[2] = corr_mag_after_250;
    tap_wr[3] = corr_mag_after_500;
    tap_wr[4] = corr_mag_after_750;
    tap_wr[5] = corr_mag_after_1000;
    tap_wr_en = sync_peak && ranging_mode_enable;
    tap_index = 3'(rd_addr - RRR_ADDR_TAP_BEFORE);
  end

  rrr_tap_mem u_taps
  (
    .clk(clk),
    .srst(srst),
    .wr_en(tap_wr_en),
    .wr_data(tap_wr),
    .rd_index(tap_index),
    .rd_data(tap_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Time-of-flight counter
  logic [7:0] phase_q, phase_d;
  logic [23:0] run_q, run_d;
  logic running_q, running_d;
  logic [23:0] flight_q, flight_d;
  logic tick;

  always_comb
  begin
    phase_d = phase_q + RRR_PHASE_STEP;
    tick = 1'b0;
    if (phase_d >= RRR_PHASE_WRAP)
    begin
      phase_d = phase_d - RRR_PHASE_WRAP;
      tick = 1'b1;
    end
    run_d = run_q;
    running_d = running_q;
    flight_d = flight_q;
    if (!ranging_mode_enable)
    begin
      running_d = 1'b0;
    end
    else if (flight_start)
    begin
      running_d = 1'b1;
      run_d = RRR_RESET_FLIGHT;
      phase_d = 8'h00;
    end
    else if (running_q && flight_stop)
    begin
      running_d = 1'b0;
      flight_d = run_q;
    end
    else if (running_q && tick)
    begin
      run_d = run_q + 24'h000001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      phase_q <= 8'h00;
      run_q <= RRR_RESET_FLIGHT;
      running_q <= 1'b0;
      flight_q <= RRR_RESET_FLIGHT;
    end
    else
    begin
      phase_q <= phase_d;
      run_q <= run_d;
      running_q <= running_d;
      flight_q <= flight_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frequency offset estimate
  rrr_state_t st_q, st_d;
  logic [15:0] acc_q, acc_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] fo_q, fo_d;

  always_comb
  begin
    st_d = st_q;
    acc_d = acc_q;
    cnt_d = cnt_q;
    fo_d = fo_q;
    case (st_q)
      RRR_IDLE:
      begin
        if (ranging_mode_enable && header_detected)
        begin
          fo_d = freq_sample;
          acc_d = {{8{freq_sample[7]}}, freq_sample};
          cnt_d = 8'h01;
          st_d = RRR_HEADER;
        end
      end
      RRR_HEADER, RRR_FRAME:
      begin
        if (!ranging_mode_enable)
        begin
          st_d = RRR_IDLE;
        end
        else if (frame_end)
        begin
          fo_d = avg_byte(acc_q, cnt_q);
          st_d = RRR_IDLE;
        end
        else if (freq_sample_valid && cnt_q != 8'hff)
        begin
          acc_d = acc_q + {{8{freq_sample[7]}}, freq_sample};
          cnt_d = cnt_q + 8'h01;
          st_d = RRR_FRAME;
        end
      end
      default:
      begin
        st_d = RRR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= RRR_IDLE;
      acc_q <= 16'h0000;
      cnt_q <= 8'h00;
      fo_q <= RRR_RESET_BYTE;
    end
    else
    begin
      st_q <= st_d;
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      fo_q <= fo_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  logic [7:0] rdat_q, rdat_d;
  logic rval_q, rval_d;
  logic tap_sel_q, tap_sel_d;

  always_comb
  begin
    rval_d = rd_en;
    tap_sel_d = rd_en && ranging_mode_enable && is_tap_addr(rd_addr);
    rdat_d = RRR_RESET_BYTE;
    if (rd_en && ranging_mode_enable)
    begin
      case (rd_addr)
        RRR_ADDR_FREQ_OFFSET: rdat_d = fo_q;
        RRR_ADDR_FLIGHT_B0: rdat_d = flight_q[7:0];
        RRR_ADDR_FLIGHT_B1: rdat_d = flight_q[15:8];
        RRR_ADDR_FLIGHT_B2: rdat_d = flight_q[23:16];
        default: rdat_d = RRR_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdat_q <= RRR_RESET_BYTE;
      rval_q <= 1'b0;
      tap_sel_q <= 1'b0;
    end
    else
    begin
      rdat_q <= rdat_d;
      rval_q <= rval_d;
      tap_sel_q <= tap_sel_d;
    end
  end

  assign rd_data = tap_sel_q ? tap_rd : rdat_q;
  assign rd_valid = rval_q;
  assign freq_offset_value = fo_q;
  assign flight_count = flight_q;
endmodule // rrr_regs
`default_nettype wire

// File: design/rrr_pkg.sv
`default_nettype none
package rrr_pkg;
  localparam logic [6:0] RRR_ADDR_TAP_BEFORE = 7'h76;
  localparam logic [6:0] RRR_ADDR_TAP_PEAK = 7'h77;
  localparam logic [6:0] RRR_ADDR_TAP_250 = 7'h78;
  localparam logic [6:0] RRR_ADDR_TAP_500 = 7'h79;
  localparam logic [6:0] RRR_ADDR_TAP_750 = 7'h7a;
  localparam logic [6:0] RRR_ADDR_TAP_1000 = 7'h7b;
  localparam logic [6:0] RRR_ADDR_FREQ_OFFSET = 7'h7c;
  localparam logic [6:0] RRR_ADDR_FLIGHT_B0 = 7'h7d;
  localparam logic [6:0] RRR_ADDR_FLIGHT_B1 = 7'h7e;
  localparam logic [6:0] RRR_ADDR_FLIGHT_B2 = 7'h7f;
  localparam int RRR_TAP_COUNT = 6;
  localparam logic [7:0] RRR_RESET_BYTE = 8'h00;
  localparam logic [23:0] RRR_RESET_FLIGHT = 24'h000000;
  localparam int RRR_CLK_HZ = 100000000;
  localparam int RRR_TIMER_HZ = 16000000;
  localparam int RRR_TAP_SPACING_NS = 250;
  // 16 MHz tick by phase accumulator: add TIMER_HZ/gcd, wrap at CLK_HZ/gcd
  localparam logic [7:0] RRR_PHASE_STEP = 8'(RRR_TIMER_HZ / 4000000);
  localparam logic [7:0] RRR_PHASE_WRAP = 8'(RRR_CLK_HZ / 4000000);
  typedef enum logic [2:0]
  {
    RRR_IDLE = 3'b001,
    RRR_HEADER = 3'b010,
    RRR_FRAME = 3'b100
  } rrr_state_t;
endpackage
`default_nettype wire

// File: design/rrr_tap_mem.sv
`default_nettype none
module rrr_tap_mem
  import rrr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data [RRR_TAP_COUNT],
  input wire logic [2:0] rd_index,
  output logic [7:0] rd_data
);
  logic [7:0] mem_q [RRR_TAP_COUNT];
  logic [7:0] mem_d [RRR_TAP_COUNT];
  logic [7:0] rd_q;
  logic [7:0] rd_d;

  always_comb
  begin
    mem_d = mem_q;
    if (wr_en)
    begin
      mem_d = wr_data;
    end
    rd_d = (int'(rd_index) < RRR_TAP_COUNT) ? mem_q[rd_index] : RRR_RESET_BYTE;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < RRR_TAP_COUNT; i++)
      begin
        mem_q[i] <= RRR_RESET_BYTE;
      end
      rd_q <= RRR_RESET_BYTE;
    end
    else
    begin
      mem_q <= mem_d;
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
endmodule // rrr_tap_mem
`default_nettype wire

// File: tb/rrr_regs_properties.sv
`default_nettype none
module rrr_regs_properties
  import rrr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ranging_mode_enable,
  input wire logic header_detected,
  input wire logic frame_end,
  input wire logic flight_stop,
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [7:0] freq_offset_value,
  input wire logic [23:0] flight_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  // Results may move only on these events or one cycle after
  logic ev;
  logic ev_q;
  logic calm;
  assign ev = header_detected | frame_end | flight_stop;
  assign calm = !ev && !ev_q && ranging_mode_enable && rd_en;
  always_ff @(posedge clk) ev_q <= ev;
  ////////////////////////////////////////////////////////////
  property p_answer; rd_en |=> rd_valid; endproperty
  a_answer: assert property (p_answer) else $error("no read answer");
  property p_quiet; !rd_en |=> !rd_valid && rd_data == 8'h00; endproperty
  a_quiet: assert property (p_quiet) else $error("spurious read");
  property p_off; rd_en && !ranging_mode_enable |=> rd_data == 8'h00; endproperty
  a_off: assert property (p_off) else $error("read while disabled");
  property p_low;
    calm && rd_addr == RRR_ADDR_FLIGHT_B0 |=> rd_data == flight_count[7:0];
  endproperty
  a_low: assert property (p_low) else $error("flight low byte");
  property p_mid;
    calm && rd_addr == RRR_ADDR_FLIGHT_B1 |=> rd_data == flight_count[15:8];
  endproperty
  a_mid: assert property (p_mid) else $error("flight mid byte");
  property p_freq;
    calm && rd_addr == RRR_ADDR_FREQ_OFFSET |=> rd_data == freq_offset_value;
  endproperty
  a_freq: assert property (p_freq) else $error("offset read");
  property p_hold; !ev && !ev_q |=> $stable(freq_offset_value); endproperty
  a_hold: assert property (p_hold) else $error("offset moved");
  property p_fhold; !ev && !ev_q |=> $stable(flight_count); endproperty
  a_fhold: assert property (p_fhold) else $error("flight moved");
endmodule // rrr_regs_properties
bind rrr_regs rrr_regs_properties u_props (.clk(clk), .srst(srst),
  .ranging_mode_enable(ranging_mode_enable), .header_detected(header_detected),
  .frame_end(frame_end), .flight_stop(flight_stop), .rd_en(rd_en),
  .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
  .freq_offset_value(freq_offset_value), .flight_count(flight_count));
`default_nettype wire

// File: tb/rrr_host_model.sv
`default_nettype none
module rrr_host_model (
  input wire logic clk,
  output logic rd_en,
  output logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    rd_en = 1'b0;
    rd_addr = 7'h00;
  end
  // One read, answer taken one cycle later
  task automatic read(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    rd_addr = ~a;
    d = rd_data;
    v = rd_valid;
  endtask
endmodule // rrr_host_model
`default_nettype wire

// File: tb/test_ranging_result_registers.sv
`default_nettype none
module test_ranging_result_registers
  import rrr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic en = 1'b1, pk = 1'b0, fst = 1'b0, fsp = 1'b0, hd = 1'b0, fv = 1'b0, fe = 1'b0;
  logic [7:0] mag [6];
  logic [7:0] fs = 8'h00;
  logic rd_en, rd_valid;
  logic [6:0] rd_addr;
  logic [7:0] rd_data, fo;
  logic [23:0] fc;
  int miscompares = 0, n_checks = 0, cyc = 0;
  initial
  begin
    forever #5 clk = ~clk;
  end
  rrr_regs dut (.clk(clk), .srst(srst), .ranging_mode_enable(en), .sync_peak(pk),
    .corr_mag_before_peak(mag[0]), .corr_mag_at_peak(mag[1]), .corr_mag_after_250(mag[2]),
    .corr_mag_after_500(mag[3]), .corr_mag_after_750(mag[4]), .corr_mag_after_1000(mag[5]),
    .flight_start(fst), .flight_stop(fsp), .header_detected(hd), .freq_sample_valid(fv),
    .freq_sample(fs), .frame_end(fe), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .freq_offset_value(fo), .flight_count(fc));
  rrr_host_model host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_near(input string s, input int e, input logic [23:0] g);
    n_checks++;
    if (g !== 24'(e) && g !== 24'(e - 1) && g !== 24'(e + 1))
    begin
      miscompares++;
      $display("mismatch %s expected %0d seen %h", s, e, g);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.read(a, d, v);
    chk("rd_valid", 8'h01, 8'(v));
    chk("rd_data", e, d);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 10; i++)
      rd(RRR_ADDR_TAP_BEFORE + 7'(i), RRR_RESET_BYTE);
  endtask
  task automatic t_taps();
    logic [7:0] t [6] = '{8'h11, 8'hff, 8'h00, 8'h80, 8'h7f, 8'h01};
    @(negedge clk);
    mag = t;
    pk = 1'b1;
    @(negedge clk);
    pk = 1'b0;
    mag = '{6{8'h5a}};
    for (int i = 0; i < 6; i++)
      rd(RRR_ADDR_TAP_BEFORE + 7'(i), t[i]);
  endtask
  task automatic t_freq();
    @(negedge clk);
    fs = 8'hf0;
    hd = 1'b1;
    @(negedge clk);
    hd = 1'b0;
    rd(RRR_ADDR_FREQ_OFFSET, 8'hf0);
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk);
      fs = 8'hec - 8'(4 * i);
      fv = 1'b1;
    end
    @(negedge clk);
    fv = 1'b0;
    fe = 1'b1;
    @(negedge clk);
    fe = 1'b0;
    rd(RRR_ADDR_FREQ_OFFSET, 8'hec);
    chk("freq_offset_value", 8'hec, fo);
  endtask
  task automatic t_flight();
    logic [7:0] b [3];
    logic v;
    @(negedge clk);
    fst = 1'b1;
    @(negedge clk);
    fst = 1'b0;
    repeat (1799) @(negedge clk);
    fsp = 1'b1;
    @(negedge clk);
    fsp = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      host.read(RRR_ADDR_FLIGHT_B0 + 7'(i), b[i], v);
      chk("flight rd_valid", 8'h01, 8'(v));
    end
    chk_near("flight bytes", 288, {b[2], b[1], b[0]});
    chk_near("flight_count", 288, fc);
    chk("flight low", 8'h1f, b[0]);
  endtask
  task automatic t_off();
    @(negedge clk);
    en = 1'b0;
    rd(RRR_ADDR_TAP_PEAK, 8'h00);
    pk = 1'b1;
    @(negedge clk);
    pk = 1'b0;
    en = 1'b1;
    rd(RRR_ADDR_TAP_PEAK, 8'hff);
    rd(7'h10, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    mag = '{6{8'h00}};
    repeat (12) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_taps();
    t_freq();
    t_flight();
    t_off();
    wrap_up();
  end
endmodule // test_ranging_result_registers
`default_nettype wire
